// file: csb_map.svh
// Purpose: Offsets, fields, reset values and codes of the checked subtractor
// Assumes: 32-bit APB data, one aligned word per register
// Notes: Definitions only
`ifndef CSB_MAP_SVH
`define CSB_MAP_SVH

// Register byte offsets
`define CSB_CONFIG_OFS 8'h00
`define CSB_CYCLE_OFS 8'h04
`define CSB_STATUS_OFS 8'h08
`define CSB_RESULT_OFS 8'h0c
`define CSB_MSGID_OFS 8'h10
`define CSB_MSGCNT_OFS 8'h14
`define CSB_MSGARG1_OFS 8'h18
`define CSB_MSGARG2_OFS 8'h1c

// Config fields
`define CSB_CFG_TYPE_LSB 0
`define CSB_CFG_EXP_STATE_BIT 2
`define CSB_CFG_EXP_DIAG_BIT 3
`define CSB_CFG_BLOCK_LSB 8
`define CSB_CONFIG_RST 32'h0000_0000
`define CSB_CYCLE_RST 16'h0013

// Status fields
`define CSB_STS_DIAG_LSB 4

// Diagnostic codes
`define CSB_DIAG_OK 2'h0
`define CSB_DIAG_UNDER 2'h1
`define CSB_DIAG_OVER 2'h2

// Message identifiers
`define CSB_MSG_UNDER 16'h4080
`define CSB_MSG_OVER 16'h4081

// Result type limits, held at 34 bits signed
`define CSB_INT16_MIN 34'h3_ffff_8000
`define CSB_INT16_MAX 34'h0_0000_7fff
`define CSB_UINT16_MAX 34'h0_0000_ffff
`define CSB_INT32_MIN 34'h3_8000_0000
`define CSB_INT32_MAX 34'h0_7fff_ffff
`define CSB_UINT32_MAX 34'h0_ffff_ffff

`endif

// file: csb_pkg.sv
// Purpose: Types of the checked subtractor
// Assumes: Codes of csb_map.svh
// Notes: State codes equal the reported state numbers
package csb_pkg;

  // Operand and result type
  typedef enum logic [1:0] {
    CSB_INT16 = 2'h0,
    CSB_UINT16 = 2'h1,
    CSB_INT32 = 2'h2,
    CSB_UINT32 = 2'h3
  } csb_dtype_e;

  // Block state, codes 0, 3, 6 and 7 unused
  typedef enum logic [2:0] {
    CSB_RUN = 3'h1,
    CSB_STOP = 3'h2,
    CSB_ERROR = 3'h4,
    CSB_RESET = 3'h5
  } csb_state_e;

endpackage : csb_pkg

// file: csb_op_if.sv
// Purpose: Carries operands and range verdict between core and checker
// Assumes: Single clock, combinational checker
// Notes: None
`timescale 1ns/1ps
`default_nettype none

interface csb_op_if;
  logic [31:0] minuend;
  logic [31:0] subtrahend;
  csb_pkg::csb_dtype_e dtype;
  logic [31:0] difference;
  logic underflow;
  logic overflow;

  modport core (output minuend, output subtrahend, output dtype,
                input difference, input underflow, input overflow);
  modport chk (input minuend, input subtrahend, input dtype,
               output difference, output underflow, output overflow);
endinterface : csb_op_if

`default_nettype wire

// file: csb_range_check.sv
// Purpose: Subtracts and range-checks against the configured result type
// Assumes: Operands of 16-bit types sit in the low half
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "csb_map.svh"

module csb_range_check (
  // Operands and verdict
  csb_op_if.chk op
);

  // Widen an operand to 34 bits, signed or unsigned per type
  function automatic logic signed [33:0] csb_ext(input logic [31:0] v,
                                                 input csb_pkg::csb_dtype_e t);
    case (t)
      csb_pkg::CSB_INT16: csb_ext = {{18{v[15]}}, v[15:0]};
      csb_pkg::CSB_UINT16: csb_ext = {18'h0, v[15:0]};
      csb_pkg::CSB_INT32: csb_ext = {{2{v[31]}}, v};
      default: csb_ext = {2'h0, v};
    endcase
  endfunction : csb_ext

  logic signed [33:0] full_diff;
  logic signed [33:0] lim_min;
  logic signed [33:0] lim_max;

  // 34 bits hold any 32-bit difference without wrapping
  assign full_diff = csb_ext(op.minuend, op.dtype) - csb_ext(op.subtrahend, op.dtype);
  // Limits follow signedness and width of the type
  assign lim_min = (op.dtype == csb_pkg::CSB_INT16) ? `CSB_INT16_MIN :
                   (op.dtype == csb_pkg::CSB_INT32) ? `CSB_INT32_MIN : 34'h0;
  assign lim_max = (op.dtype == csb_pkg::CSB_INT16) ? `CSB_INT16_MAX :
                   (op.dtype == csb_pkg::CSB_UINT16) ? `CSB_UINT16_MAX :
                   (op.dtype == csb_pkg::CSB_INT32) ? `CSB_INT32_MAX : `CSB_UINT32_MAX;
  assign op.underflow = full_diff < lim_min;
  assign op.overflow = full_diff > lim_max;
  // Result is the low 32 bits of the 34-bit difference
  assign op.difference = full_diff[31:0];

endmodule : csb_range_check

`default_nettype wire

// file: csb_cycle_timer.sv
// Purpose: Makes the processing-cycle enable pulse
// Assumes: Period register holds cycles minus one
// Notes: A new period takes effect at the next wrap
`timescale 1ns/1ps
`default_nettype none

module csb_cycle_timer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Period and pulse
  input wire logic [15:0] period,
  output logic tick
);

  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic wrap;

  // Count down; reload on wrap so a shrinking period never stalls
  assign wrap = (count_reg == 16'h0000);
  assign count_next = wrap ? period : 16'(count_reg - 16'h0001);
  assign tick = wrap;

  // Down counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 16'h0000;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule : csb_cycle_timer

`default_nettype wire

// file: csb_checked_subtractor.sv
// Purpose: Cyclic checked subtraction unit with state, diagnosis and messages
// Assumes: Operand, run and acknowledge inputs come from logic on pclk
// Notes: APB3 slave, zero wait states, unmapped addresses answer pslverr
`timescale 1ns/1ps
`default_nettype none
`include "csb_map.svh"

module csb_checked_subtractor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Operands and group control
  input wire logic [31:0] minuend_in,
  input wire logic [31:0] subtrahend_in,
  input wire logic block_run_enable,
  input wire logic group_fault_acknowledge,
  // Results
  output logic [31:0] difference_out,
  output logic error_out,
  // Cyclic process image
  output logic [2:0] image_state_out,
  output logic [1:0] image_diag_out,
  // Diagnostic message to the owning group
  output logic msg_valid,
  output logic [15:0] msg_text_id,
  output logic [15:0] msg_block_num,
  output logic [31:0] msg_arg1,
  output logic [31:0] msg_arg2
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  ////////////////////////////////////////////////////////////////////////////

  // Software-visible configuration
  logic [31:0] config_reg;
  logic [15:0] cycle_reg;

  // Block state and its outputs
  csb_pkg::csb_state_e state_reg;
  csb_pkg::csb_state_e state_next;
  logic [1:0] diag_reg;
  logic [1:0] diag_next;
  logic [31:0] result_reg;
  logic [31:0] result_next;
  logic error_reg;
  logic error_next;
  logic [2:0] img_state_reg;
  logic [1:0] img_diag_reg;

  // Message holding registers
  logic msg_valid_reg;
  logic [15:0] msg_id_reg;
  logic [15:0] msg_cnt_reg;
  logic [31:0] msg_arg1_reg;
  logic [31:0] msg_arg2_reg;

  // Decoded configuration
  csb_pkg::csb_dtype_e cfg_dtype;
  logic cfg_expose_state;
  logic cfg_expose_diag;
  logic [15:0] cfg_block;

  // Checker verdict and cycle pulse
  logic tick;
  logic range_err;
  logic enter_error;

  // APB decode
  logic apb_access;
  logic apb_wr;
  logic hit_config;
  logic hit_cycle;
  logic hit_status;
  logic hit_result;
  logic hit_msgid;
  logic hit_msgcnt;
  logic hit_arg1;
  logic hit_arg2;
  logic addr_mapped;
  logic [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Submodules
  ////////////////////////////////////////////////////////////////////////////

  csb_op_if op ();

  // Operands go to the checker unregistered; the result is sampled on tick
  assign op.minuend = minuend_in;
  assign op.subtrahend = subtrahend_in;
  assign op.dtype = cfg_dtype;

  // Range checker
  csb_range_check u_check (
    .op (op.chk)
  );

  // Processing cycle divider
  csb_cycle_timer u_timer (
    .pclk (pclk),
    .presetn (presetn),
    .period (cycle_reg),
    .tick (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB slave
  ////////////////////////////////////////////////////////////////////////////

  // Field split of the configuration word
  assign cfg_dtype = csb_pkg::csb_dtype_e'(config_reg[`CSB_CFG_TYPE_LSB +: 2]);
  assign cfg_expose_state = config_reg[`CSB_CFG_EXP_STATE_BIT];
  assign cfg_expose_diag = config_reg[`CSB_CFG_EXP_DIAG_BIT];
  assign cfg_block = config_reg[`CSB_CFG_BLOCK_LSB +: 16];

  // Address decode; always ready, so every access lasts two cycles
  assign apb_access = psel && penable;
  assign hit_config = (paddr == `CSB_CONFIG_OFS);
  assign hit_cycle = (paddr == `CSB_CYCLE_OFS);
  assign hit_status = (paddr == `CSB_STATUS_OFS);
  assign hit_result = (paddr == `CSB_RESULT_OFS);
  assign hit_msgid = (paddr == `CSB_MSGID_OFS);
  assign hit_msgcnt = (paddr == `CSB_MSGCNT_OFS);
  assign hit_arg1 = (paddr == `CSB_MSGARG1_OFS);
  assign hit_arg2 = (paddr == `CSB_MSGARG2_OFS);
  assign addr_mapped = hit_config || hit_cycle || hit_status || hit_result ||
                       hit_msgid || hit_msgcnt || hit_arg1 || hit_arg2;
  assign apb_wr = apb_access && pwrite && addr_mapped;

  // Read selection; unused bits read as zero
  assign rd_mux = hit_config ? config_reg :
                  hit_cycle ? {16'h0000, cycle_reg} :
                  hit_status ? {26'h0, diag_reg, 1'b0, state_reg} :
                  hit_result ? result_reg :
                  hit_msgid ? {16'h0000, msg_id_reg} :
                  hit_msgcnt ? {16'h0000, msg_cnt_reg} :
                  hit_arg1 ? msg_arg1_reg :
                  hit_arg2 ? msg_arg2_reg : 32'h0000_0000;

  // Handshake outputs are combinational
  assign pready = 1'b1;
  assign pslverr = apb_access && !addr_mapped;
  assign prdata = (apb_access && !pwrite) ? rd_mux : 32'h0000_0000;

  // Writable registers; writes to read-only words are dropped quietly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg <= `CSB_CONFIG_RST;
      cycle_reg <= `CSB_CYCLE_RST;
    end else if (apb_wr && hit_config) begin
      config_reg <= {8'h00, pwdata[23:8], 4'h0, pwdata[3:0]};
    end else if (apb_wr && hit_cycle) begin
      cycle_reg <= pwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State machine
  ////////////////////////////////////////////////////////////////////////////

  assign range_err = op.underflow || op.overflow;

  // Next state; run enable false overrides everything, even a held error
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      csb_pkg::CSB_RUN: begin
        if (range_err) begin
          state_next = csb_pkg::CSB_ERROR;
        end
      end
      csb_pkg::CSB_STOP: begin
        // A bad difference must never show in RUN, not even for one cycle
        state_next = range_err ? csb_pkg::CSB_ERROR : csb_pkg::CSB_RUN;
      end
      csb_pkg::CSB_ERROR: begin
        if (!range_err && group_fault_acknowledge) begin
          state_next = csb_pkg::CSB_RESET;
        end
      end
      csb_pkg::CSB_RESET: begin
        if (range_err) begin
          state_next = csb_pkg::CSB_ERROR;
        end else if (!group_fault_acknowledge) begin
          state_next = csb_pkg::CSB_RUN;
        end
      end
      default: begin
        state_next = csb_pkg::CSB_STOP;
      end
    endcase
    if (!block_run_enable) begin
      state_next = csb_pkg::CSB_STOP;
    end
  end

  // Output values follow the state being entered
  assign result_next = (state_next == csb_pkg::CSB_RUN) ? op.difference : 32'h0000_0000;
  assign error_next = (state_next == csb_pkg::CSB_ERROR);

  // Diagnosis of the current subtraction
  assign diag_next = op.underflow ? `CSB_DIAG_UNDER :
                     op.overflow ? `CSB_DIAG_OVER : `CSB_DIAG_OK;

  // A message goes out only on the way into ERROR, not every cycle in it
  assign enter_error = tick && (state_next == csb_pkg::CSB_ERROR) &&
                       (state_reg != csb_pkg::CSB_ERROR);

  // State, result and diagnosis advance once per processing cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= csb_pkg::CSB_STOP;
      result_reg <= 32'h0000_0000;
      error_reg <= 1'b0;
      diag_reg <= `CSB_DIAG_OK;
    end else if (tick) begin
      state_reg <= state_next;
      result_reg <= result_next;
      error_reg <= error_next;
      diag_reg <= diag_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Process image and messages
  ////////////////////////////////////////////////////////////////////////////

  // Masked copies; a cleared flag shows zero so the image carries no stale code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      img_state_reg <= 3'h0;
      img_diag_reg <= 2'h0;
    end else if (tick) begin
      img_state_reg <= cfg_expose_state ? state_next : 3'h0;
      img_diag_reg <= cfg_expose_diag ? diag_next : 2'h0;
    end
  end

  // Message: one-cycle valid, payload held until the next message
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msg_valid_reg <= 1'b0;
      msg_id_reg <= 16'h0000;
      msg_cnt_reg <= 16'h0000;
      msg_arg1_reg <= 32'h0000_0000;
      msg_arg2_reg <= 32'h0000_0000;
    end else begin
      msg_valid_reg <= enter_error;
      if (enter_error) begin
        msg_id_reg <= op.underflow ? `CSB_MSG_UNDER : `CSB_MSG_OVER;
        msg_cnt_reg <= 16'(msg_cnt_reg + 16'h0001);
        msg_arg1_reg <= minuend_in;
        msg_arg2_reg <= subtrahend_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  ////////////////////////////////////////////////////////////////////////////

  assign difference_out = result_reg;
  assign error_out = error_reg;
  assign image_state_out = img_state_reg;
  assign image_diag_out = img_diag_reg;
  assign msg_valid = msg_valid_reg;
  assign msg_text_id = msg_id_reg;
  assign msg_block_num = cfg_block;
  assign msg_arg1 = msg_arg1_reg;
  assign msg_arg2 = msg_arg2_reg;

endmodule : csb_checked_subtractor

`default_nettype wire

// file: csb_checked_subtractor_asserts.sv
// Purpose: Port checks on the checked subtractor
// Assumes: Bench turns image flags on for state antecedents
// Notes: Bound after the module
`timescale 1ns/1ps
`default_nettype none
`include "csb_map.svh"

module csb_checked_subtractor_asserts (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Results and message
  input wire logic [31:0] difference_out,
  input wire logic error_out,
  input wire logic [2:0] image_state_out,
  input wire logic msg_valid,
  input wire logic [15:0] msg_text_id
);
  // One domain, so one clock and reset serve every check
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////
  // Output levels tied to the reported state
  chk_err_zero: assert property (error_out |-> difference_out == 32'h0)
    else $error("result not zero while in error");
  chk_err_code: assert property (error_out |-> image_state_out inside {3'h0, 3'h4})
    else $error("error output outside error state");
  chk_quiet_outs: assert property (image_state_out inside {3'h2, 3'h5} |-> !error_out && difference_out == 32'h0)
    else $error("outputs not cleared in stop or reset");
  chk_run_clean: assert property (image_state_out == 3'h1 |-> !error_out)
    else $error("error output high in run");
  chk_code_set: assert property (!(image_state_out inside {3'h3, 3'h6, 3'h7}))
    else $error("unused state code shown");
  chk_leave_err: assert property ($fell(error_out) |-> image_state_out inside {3'h0, 3'h2, 3'h5})
    else $error("error left to a wrong state");
  // Message leaves with the entry into error and lasts one cycle
  chk_msg_after: assert property ($rose(error_out) |-> msg_valid)
    else $error("no message after error entry");
  chk_msg_pulse: assert property (msg_valid |-> (msg_text_id == `CSB_MSG_UNDER || msg_text_id == `CSB_MSG_OVER) ##1 !msg_valid)
    else $error("bad message id or pulse length");
  // Places above the last register answer at once with an error and no data
  chk_unmapped: assert property (psel && penable && paddr > 8'h1c |-> pready && pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
endmodule : csb_checked_subtractor_asserts

bind csb_checked_subtractor csb_checked_subtractor_asserts u_csb_checked_subtractor_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .difference_out(difference_out), .error_out(error_out),
  .image_state_out(image_state_out), .msg_valid(msg_valid), .msg_text_id(msg_text_id));

`default_nettype wire

// file: csb_group_model.sv
// Purpose: Owning group logic beside the subtractor
// Assumes: Bench commands the acknowledge
// Notes: Registered, so acknowledge lags the command by a clock
`timescale 1ns/1ps
`default_nettype none

module csb_group_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench command and block message
  input wire logic ack_cmd,
  input wire logic msg_valid,
  // Acknowledge and message tally
  output logic group_fault_acknowledge,
  output logic [15:0] msg_count
);
  // A real group answers from its own flops, never in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group_fault_acknowledge <= 1'b0;
      msg_count <= 16'h0;
    end else begin
      group_fault_acknowledge <= ack_cmd;
      msg_count <= msg_count + {15'h0, msg_valid};
    end
  end
endmodule : csb_group_model

`default_nettype wire

// file: csb_checked_subtractor_tb.sv
// Purpose: Self-checking bench of the checked subtractor
// Assumes: Cycle register set to 0, one tick per clock
// Notes: Expected values queued by drivers, popped by the monitor
`timescale 1ns/1ps
`default_nettype none
`include "csb_map.svh"

module csb_checked_subtractor_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, chk_req, fs, fd;
  logic block_run_enable, ack_cmd, group_fault_acknowledge, error_out, msg_valid;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, minuend_in, subtrahend_in, difference_out, msg_arg1, msg_arg2, a, b;
  logic [2:0] image_state_out;
  logic [1:0] image_diag_out;
  logic [15:0] msg_text_id, msg_block_num, blk, msg_count, nmsg;
  logic [95:0] m;
  logic [37:0] out_q[$];
  logic [32:0] rd_q[$];
  logic [95:0] msg_q[$];
  int errors, checks_done;

  csb_checked_subtractor u_csb_checked_subtractor (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .minuend_in(minuend_in), .subtrahend_in(subtrahend_in),
    .block_run_enable(block_run_enable), .group_fault_acknowledge(group_fault_acknowledge),
    .difference_out(difference_out), .error_out(error_out), .image_state_out(image_state_out),
    .image_diag_out(image_diag_out), .msg_valid(msg_valid), .msg_text_id(msg_text_id),
    .msg_block_num(msg_block_num), .msg_arg1(msg_arg1), .msg_arg2(msg_arg2));
  csb_group_model u_csb_group_model (.pclk(pclk), .presetn(presetn), .ack_cmd(ack_cmd),
    .msg_valid(msg_valid), .group_fault_acknowledge(group_fault_acknowledge), .msg_count(msg_count));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////
  task cmp(input string n, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp

  task results;
    if (errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results

  // Request held until pready is seen, then released for one idle edge
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task rd(input logic [7:0] ad, input logic [31:0] d, input logic e);
    rd_q.push_back({e, d});
    apb(1'b0, ad, 32'h0);
  endtask : rd

  function automatic longint ext(input logic [1:0] t, input logic [31:0] v);
    case (t)
      2'h0: return longint'($signed(v[15:0]));
      2'h1: return longint'(v[15:0]);
      2'h2: return longint'($signed(v));
      default: return longint'(v);
    endcase
  endfunction : ext

  // Diag code and truncated difference from the type's own limits
  function automatic logic [33:0] model(input logic [1:0] t, input logic [31:0] x, input logic [31:0] y);
    longint d;
    longint hi;
    longint lo;
    d = ext(t, x) - ext(t, y);
    hi = t[1] ? (t[0] ? 64'hffff_ffff : 64'h7fff_ffff) : (t[0] ? 64'hffff : 64'h7fff);
    lo = t[0] ? 64'h0 : -hi - 1;
    return {d < lo ? 2'h1 : (d > hi ? 2'h2 : 2'h0), d[31:0]};
  endfunction : model

  // Four ticks let the lagging acknowledge and state moves settle
  task expect_out(input logic e, input logic [2:0] s, input logic [1:0] g, input logic [31:0] d);
    repeat (4) @(posedge pclk);
    out_q.push_back({e, fs ? s : 3'h0, fd ? g : 2'h0, d});
    chk_req <= 1'b1;
    @(posedge pclk);
    chk_req <= 1'b0;
  endtask : expect_out

  task err_case(input logic [1:0] t, input logic [31:0] x, input logic [31:0] y);
    logic [1:0] g;
    g = 2'(model(t, x, y) >> 32);
    minuend_in <= x;
    subtrahend_in <= y;
    msg_q.push_back({g == 2'h1 ? `CSB_MSG_UNDER : `CSB_MSG_OVER, blk, x, y});
    nmsg = nmsg + 16'h1;
    expect_out(1'b1, 3'h4, g, 32'h0);
    ack_cmd <= 1'b1;
    expect_out(1'b1, 3'h4, g, 32'h0);
    minuend_in <= 32'h5;
    subtrahend_in <= 32'h3;
    expect_out(1'b0, 3'h5, 2'h0, 32'h0);
    ack_cmd <= 1'b0;
    expect_out(1'b0, 3'h1, 2'h0, 32'h2);
    block_run_enable <= 1'b0;
    expect_out(1'b0, 3'h2, 2'h0, 32'h0);
    block_run_enable <= 1'b1;
  endtask : err_case
  ////////////////////////////////////////////////////////////
  // Monitor takes the oldest note whenever a result shows
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) cmp("apb_read", {31'h0, rd_q.pop_front()}, {31'h0, pslverr, prdata});
    if (chk_req) cmp("outputs", {26'h0, out_q.pop_front()}, {26'h0, error_out, image_state_out, image_diag_out, difference_out});
    if (msg_valid) begin
      m = msg_q.pop_front();
      cmp("msg_head", {32'h0, m[95:64]}, {32'h0, msg_text_id, msg_block_num});
      cmp("msg_args", m[63:0], {msg_arg1, msg_arg2});
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, minuend_in, subtrahend_in} = '0;
    {block_run_enable, ack_cmd, chk_req, fs, fd, nmsg, blk, errors, checks_done} = '0;
    void'($urandom(65954));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`CSB_CONFIG_OFS, `CSB_CONFIG_RST, 1'b0);
    rd(`CSB_CYCLE_OFS, {16'h0, `CSB_CYCLE_RST}, 1'b0);
    rd(8'h40, 32'h0, 1'b1);
    apb(1'b1, `CSB_STATUS_OFS, 32'hffff_ffff);
    rd(`CSB_STATUS_OFS, 32'h2, 1'b0);
    apb(1'b1, `CSB_CYCLE_OFS, 32'h0);
    repeat (25) @(posedge pclk);
    block_run_enable <= 1'b1;
    for (int t = 0; t < 4; t++) begin
      blk = 16'($urandom);
      fs = t[0];
      fd = t[1];
      apb(1'b1, `CSB_CONFIG_OFS, {8'h0, blk, 4'h0, fd, fs, 2'(t)});
      rd(`CSB_CONFIG_OFS, {8'h0, blk, 4'h0, fd, fs, 2'(t)}, 1'b0);
      repeat (4) begin
        a = $urandom % 30000;
        b = $urandom % (a + 1);
        minuend_in <= a;
        subtrahend_in <= b;
        expect_out(1'b0, 3'h1, 2'h0, 32'(model(2'(t), a, b)));
      end
      err_case(2'(t), t[0] ? 32'h0 : (t[1] ? 32'h8000_0000 : 32'h8000), 32'h1);
      if (!t[0]) err_case(2'(t), t[1] ? 32'h7fff_ffff : 32'h7fff, t[1] ? 32'hffff_ffff : 32'hffff);
    end
    rd(`CSB_MSGCNT_OFS, {16'h0, nmsg}, 1'b0);
    cmp("group_msgs", {48'h0, nmsg}, {48'h0, msg_count});
    rd(`CSB_STATUS_OFS, 32'h1, 1'b0);
    results();
  end

  // Whole run is well under a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    results();
  end
endmodule : csb_checked_subtractor_tb

`default_nettype wire
